// ### hw/ssu_regs.svh
// Constants for the status switch unit: opcodes, vectors, PROGRAM_STATUS_WORD fields.
// Assumes a 32-bit big-endian bit numbering mapped to [31:0] as bit0 = MSB.
`ifndef SSU_REGS_SVH
`define SSU_REGS_SVH
`define SSU_OP_LSW      8'h18
`define SSU_OP_LSW_MEM  8'hC2
`define SSU_OP_XCHG     8'h95
`define SSU_OP_SIMULATED_INTERRUPT     8'hE2
`define SSU_OP_SVC      8'hE1
`define SSU_OP_BRK      8'h88
`define SSU_OP_PSF      8'hDF
`define SSU_VEC_SQ_PTR  24'h00_0080
`define SSU_VEC_SQS     24'h00_0088
`define SSU_VEC_AF      24'h00_0048
`define SSU_VEC_SVC     24'h00_0098
`define SSU_VEC_SVCTAB  24'h00_009C
`define SSU_TIMEOUT_ST  32'h0000_0004
`define SSU_REG_LINK    4'h0
`define SSU_REG_STAT    4'h3
`define SSU_REG_NEXT    4'hC
`define SSU_REG_CODE    4'hD
`define SSU_REG_OPSW0   4'hE
`define SSU_REG_OPSW1   4'hF
// PROGRAM_STATUS_WORD bit n (0 = MSB of upper word) sits at index 31-n
`define SSU_PSW_SQS     9
`define SSU_PSW_PROT    8
`define SSU_PSW_SET_HI  27
`define SSU_PSW_SET_LO  24
`define SSU_V_FLAG      2
`define SSU_CC_W        4
`define SSU_DEVNUM_W    10
`endif

// ### hw/ssu_pkg.sv
// Types shared by the status switch unit.
// Assumes ssu_regs.svh is on the include path.
package ssu_pkg;
  typedef enum logic [2:0] {
    SSU_AF_FXDIV0, SSU_AF_QOVF, SSU_AF_FLDIV0, SSU_AF_EXPUNF, SSU_AF_EXPOVF
  } ssu_fault_e;
  typedef enum logic [2:0] {
    SSU_OP_NONE, SSU_OP_LOAD, SSU_OP_LOADR, SSU_OP_EXCH,
    SSU_OP_SIM,  SSU_OP_CALL, SSU_OP_BRKP,  SSU_OP_SYSF
  } ssu_op_e;
endpackage

// ### hw/ssu_decode.sv
// Opcode decode and privilege check for status-switching instructions.
// Assumes the opcode and current PROGRAM_STATUS_WORD are stable while instr_valid is high.
`include "ssu_regs.svh"
module ssu_decode
  import ssu_pkg::*;
(
  // Instruction
  input  wire logic [7:0]     opcode,
  input  wire logic [31:0]    psw_hi,
  // Result
  output ssu_pkg::ssu_op_e    op,
  output logic                priv_fault
);
  always_comb begin
    unique case (opcode)
      `SSU_OP_LSW_MEM: op = SSU_OP_LOAD;
      `SSU_OP_LSW:     op = SSU_OP_LOADR;
      `SSU_OP_XCHG:    op = SSU_OP_EXCH;
      `SSU_OP_SIMULATED_INTERRUPT:    op = SSU_OP_SIM;
      `SSU_OP_SVC:     op = SSU_OP_CALL;
      `SSU_OP_BRK:     op = SSU_OP_BRKP;
      `SSU_OP_PSF:     op = SSU_OP_SYSF;
      default:         op = SSU_OP_NONE;
    endcase
  end
  // Privileged unless supervisor call
  assign priv_fault = psw_hi[`SSU_PSW_PROT] && op != SSU_OP_NONE
                      && op != SSU_OP_CALL;
endmodule

// ### hw/ssu_psf_dec.sv
// One-hot decode of the privileged system function N field.
// Assumes a single-cycle strobe from the main unit.
`include "ssu_regs.svh"
module ssu_psf_dec (
  // Request
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        fire,
  input  wire logic [3:0]  n_field,
  // Result
  output logic [15:0]      func_sel
);
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_sel
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          func_sel[i] <= 1'b0;
        end else begin
          func_sel[i] <= fire && (n_field == i[3:0]);
        end
      end
    end
  endgenerate
endmodule

// ### hw/ssu_main.sv
// Operation
// - Arithmetic fault writes next instruction address to register 12 of new set.
// - Arithmetic fault saves old PROGRAM_STATUS_WORD with counter pointing at faulting instruction.
// - Arithmetic fault writes reason code 0..4 into register 13.
// - All status switching instructions except supervisor call are privileged.
// - Load status word C2 replaces whole PROGRAM_STATUS_WORD with 64-bit memory operand.
// - Condition code comes from bits 28..31 of the newly installed PROGRAM_STATUS_WORD.
// - A newly selected register set is used from the next instruction.
// - Register load 18 copies R2 to PROGRAM_STATUS_WORD 0..31, R2+1 to 32..63.
// - Exchange 95 writes PROGRAM_STATUS_WORD 0..31 into R1, then loads it from R2.
// - Exchange with R1 equal R2 copies PROGRAM_STATUS_WORD out, PROGRAM_STATUS_WORD stays unchanged.
// - New PROGRAM_STATUS_WORD from 18, C2 or 95 with bit 22 set tests queue; non-empty raises queue service.
// - Simulated interrupt E2 uses low 10 operand bits as device number.
// - Simulated interrupt with R1 zero selects set 0, else R1 low 3 bits.
// - Simulated interrupt loads registers 0 and 3 of new set, status in 3.
// - Device time-out puts 4 in register 3 and sets V for immediate.
// - Simulated interrupt acknowledges no pending real interrupt.
// - Supervisor call E1 writes operand address to register 13 bits 8..31.
// - Supervisor call saves PROGRAM_STATUS_WORD in 14/15, loads PROGRAM_STATUS_WORD word from vector.
// - Supervisor call doubles N, adds table base, loads new location counter.
// - Breakpoint 88 enters console mode without advancing location counter.
// - System function DF decodes N field to one of 16 functions.
//
// Assumes one instruction at a time; memory and device answer with ready pulses.
`include "ssu_regs.svh"
module ssu_main
  import ssu_pkg::*;
(
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            srst,
  // Instruction stream
  input  wire logic            instr_valid,
  input  wire logic [7:0]      opcode,
  input  wire logic [3:0]      r1_field,
  input  wire logic [3:0]      r2_field,
  input  wire logic [23:0]     operand_addr,
  input  wire logic [23:0]     instr_addr,
  input  wire logic [23:0]     next_addr,
  input  wire logic [31:0]     r1_data,
  input  wire logic [31:0]     r2_data,
  input  wire logic [31:0]     r2p1_data,
  // Arithmetic fault
  input  wire logic            fault_valid,
  input  wire ssu_pkg::ssu_fault_e fault_code,
  // Memory read port
  output logic                 mem_req,
  output logic [23:0]          mem_addr,
  input  wire logic            mem_ready,
  input  wire logic [31:0]     mem_rdata,
  // Device status port
  output logic                 dev_req,
  output logic [9:0]           dev_num,
  input  wire logic            dev_ready,
  input  wire logic            dev_timeout,
  input  wire logic [31:0]     dev_status,
  input  wire logic            dev_immediate,
  // Register write port
  output logic                 reg_we,
  output logic [2:0]           reg_set,
  output logic [3:0]           reg_idx,
  output logic [31:0]          reg_wdata,
  // Status and control
  output logic [63:0]          program_status_word,
  output logic [3:0]           cond_code,
  output logic [2:0]           active_set,
  output logic                 done,
  output logic                 priv_fault,
  output logic                 console_mode,
  output logic                 int_ack,
  output logic [15:0]          func_sel
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_MEM0, ST_MEM1, ST_REGW, ST_SQ_PTR, ST_SQ_CNT,
    ST_SQ_VEC, ST_DEV, ST_TAB, ST_FIN
  } ssu_st_e;

  ssu_st_e        st;
  ssu_op_e        op_dec;
  ssu_op_e        op;
  logic           dec_fault;
  logic [63:0]    new_psw;
  logic [63:0]    old_psw;
  logic [31:0]    wq [0:3];
  logic [3:0]     wq_idx [0:3];
  logic [1:0]     wq_n;
  logic [1:0]     wq_i;
  logic [2:0]     wq_set;
  logic [23:0]    op_addr;
  logic [3:0]     n_lat;
  logic           psf_fire;
  logic [23:0]    sq_addr;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  ssu_decode u_dec (
    .opcode     (opcode),
    .psw_hi     (program_status_word[63:32]),
    .op         (op_dec),
    .priv_fault (dec_fault)
  );

  ssu_psf_dec u_psf (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .fire     (psf_fire),
    .n_field  (r1_field),
    .func_sel (func_sel)
  );

  assign psf_fire = st == ST_IDLE && instr_valid && !fault_valid
                    && op_dec == SSU_OP_SYSF && !dec_fault;

  function automatic logic [2:0] set_of(input logic [63:0] w);
    set_of = w[32+`SSU_PSW_SET_LO +: 3];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st           <= ST_IDLE;
      op           <= SSU_OP_NONE;
      program_status_word          <= 64'h0000_0000_0000_0000;
      new_psw      <= 64'h0000_0000_0000_0000;
      old_psw      <= 64'h0000_0000_0000_0000;
      wq_n         <= 2'h0;
      wq_set       <= 3'h0;
      op_addr      <= 24'h00_0000;
      n_lat        <= 4'h0;
      wq_i         <= 2'h0;
      sq_addr      <= 24'h00_0000;
      mem_req      <= 1'b0;
      mem_addr     <= 24'h00_0000;
      dev_req      <= 1'b0;
      dev_num      <= 10'h000;
      done         <= 1'b0;
      priv_fault   <= 1'b0;
      console_mode <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        wq[k]     <= 32'h0000_0000;
        wq_idx[k] <= 4'h0;
      end
    end else begin
      done       <= 1'b0;
      priv_fault <= 1'b0;
      unique case (st)
        ST_IDLE: begin
          if (fault_valid) begin
            // Fault saves PROGRAM_STATUS_WORD with counter at faulting instruction
            old_psw  <= {program_status_word[63:24], instr_addr};
            wq[2]    <= {29'h0, fault_code};
            wq[3]    <= {8'h00, next_addr};
            wq_idx[2] <= `SSU_REG_CODE;
            wq_idx[3] <= `SSU_REG_NEXT;
            op       <= SSU_OP_NONE;
            mem_req  <= 1'b1;
            mem_addr <= `SSU_VEC_AF;
            st       <= ST_MEM0;
          end else if (instr_valid && op_dec != SSU_OP_NONE) begin
            op      <= op_dec;
            op_addr <= operand_addr;
            n_lat   <= r1_field;
            if (dec_fault) begin
              priv_fault <= 1'b1;
              done       <= 1'b1;
            end else begin
              unique case (op_dec)
                SSU_OP_LOAD: begin
                  mem_req  <= 1'b1;
                  mem_addr <= operand_addr;
                  st       <= ST_MEM0;
                end
                SSU_OP_LOADR: begin
                  new_psw <= {r2_data, r2p1_data};
                  wq_n    <= 2'h0;
                  st      <= ST_FIN;
                end
                SSU_OP_EXCH: begin
                  wq[0]     <= program_status_word[63:32];
                  wq_idx[0] <= r1_field;
                  wq_set    <= set_of(program_status_word);
                  wq_n      <= 2'h0;
                  wq_i      <= 2'h0;
                  // Same register: PROGRAM_STATUS_WORD left as it was
                  new_psw <= (r1_field == r2_field) ? program_status_word
                             : {r2_data, program_status_word[31:0]};
                  st      <= ST_REGW;
                end
                SSU_OP_SIM: begin
                  dev_req  <= 1'b1;
                  dev_num  <= operand_addr[`SSU_DEVNUM_W-1:0];
                  wq_set   <= (r1_field == 4'h0) ? 3'h0 : r1_data[2:0];
                  st       <= ST_DEV;
                end
                SSU_OP_CALL: begin
                  old_psw  <= {program_status_word[63:24], next_addr};
                  wq[2]    <= {8'h00, operand_addr};
                  wq_idx[2] <= `SSU_REG_CODE;
                  mem_req  <= 1'b1;
                  mem_addr <= `SSU_VEC_SVC;
                  st       <= ST_MEM0;
                end
                SSU_OP_BRKP: begin
                  console_mode <= 1'b1;
                  done         <= 1'b1;
                end
                default: done <= 1'b1;
              endcase
            end
          end
        end
        ST_MEM0: begin
          mem_req <= 1'b0;
          if (mem_ready) begin
            new_psw[63:32] <= mem_rdata;
            if (op == SSU_OP_CALL) begin
              // Table entry at base plus twice N
              mem_req  <= 1'b1;
              mem_addr <= `SSU_VEC_SVCTAB + {19'h0, n_lat, 1'b0};
              st       <= ST_TAB;
            end else begin
              mem_req  <= 1'b1;
              mem_addr <= mem_addr + 24'h00_0004;
              st       <= ST_MEM1;
            end
          end
        end
        ST_MEM1: begin
          mem_req <= 1'b0;
          if (mem_ready) begin
            new_psw[31:0] <= mem_rdata;
            if (op == SSU_OP_NONE) begin
              wq[0] <= old_psw[63:32];
              wq[1] <= old_psw[31:0];
              wq_idx[0] <= `SSU_REG_OPSW0;
              wq_idx[1] <= `SSU_REG_OPSW1;
              wq_set <= set_of({new_psw[63:32], mem_rdata});
              wq_n   <= 2'h3;
              wq_i   <= 2'h0;
              st     <= ST_REGW;
            end else begin
              wq_n <= 2'h0;
              st   <= ST_FIN;
            end
          end
        end
        ST_TAB: begin
          mem_req <= 1'b0;
          if (mem_ready) begin
            new_psw[31:0] <= {8'h00, 8'h00, mem_rdata[31:16]};
            wq[0] <= old_psw[63:32];
            wq[1] <= old_psw[31:0];
            wq_idx[0] <= `SSU_REG_OPSW0;
            wq_idx[1] <= `SSU_REG_OPSW1;
            wq_set <= set_of(new_psw);
            wq_n   <= 2'h2;
            wq_i   <= 2'h0;
            st     <= ST_REGW;
          end
        end
        ST_DEV: begin
          dev_req <= 1'b0;
          if (dev_ready || dev_timeout) begin
            wq[0]     <= {8'h00, 14'h0, dev_num};
            wq_idx[0] <= `SSU_REG_LINK;
            wq[1]     <= dev_timeout ? `SSU_TIMEOUT_ST : dev_status;
            wq_idx[1] <= `SSU_REG_STAT;
            new_psw   <= {program_status_word[63:32+`SSU_CC_W],
                          (dev_timeout && dev_immediate) ? 4'b0100 : program_status_word[35:32],
                          program_status_word[31:0]};
            wq_n <= 2'h1;
            wq_i <= 2'h0;
            st   <= ST_REGW;
          end
        end
        ST_REGW: begin
          if (wq_i == wq_n) begin
            st <= ST_FIN;
          end
          wq_i <= wq_i + 2'h1;
        end
        ST_FIN: begin
          // New set in effect for next instruction
          program_status_word  <= new_psw;
          if (new_psw[32+`SSU_PSW_SQS] &&
              (op == SSU_OP_LOAD || op == SSU_OP_LOADR || op == SSU_OP_EXCH)) begin
            mem_req  <= 1'b1;
            mem_addr <= `SSU_VEC_SQ_PTR;
            st       <= ST_SQ_PTR;
          end else begin
            done <= 1'b1;
            st   <= ST_IDLE;
          end
        end
        ST_SQ_PTR: begin
          mem_req <= 1'b0;
          if (mem_ready) begin
            sq_addr  <= mem_rdata[23:0];
            mem_req  <= 1'b1;
            mem_addr <= mem_rdata[23:0];
            st       <= ST_SQ_CNT;
          end
        end
        ST_SQ_CNT: begin
          mem_req <= 1'b0;
          if (mem_ready) begin
            if (mem_rdata[15:0] != 16'h0000) begin
              // Queue non-empty: service interrupt with new PROGRAM_STATUS_WORD as old
              old_psw   <= program_status_word;
              wq[2]     <= {8'h00, sq_addr};
              wq_idx[2] <= `SSU_REG_CODE;
              wq[3]     <= {8'h00, sq_addr};
              wq_idx[3] <= `SSU_REG_CODE;
              mem_req   <= 1'b1;
              mem_addr  <= `SSU_VEC_SQS;
              st        <= ST_SQ_VEC;
            end else begin
              done <= 1'b1;
              st   <= ST_IDLE;
            end
          end
        end
        ST_SQ_VEC: begin
          mem_req <= 1'b0;
          op <= SSU_OP_NONE;
          st <= ST_MEM0;
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_we    <= 1'b0;
      reg_set   <= 3'h0;
      reg_idx   <= 4'h0;
      reg_wdata <= 32'h0000_0000;
    end else begin
      reg_we    <= st == ST_REGW;
      reg_set   <= wq_set;
      reg_idx   <= wq_idx[wq_i];
      reg_wdata <= wq[wq_i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Derived status

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cond_code  <= 4'h0;
      active_set <= 3'h0;
      int_ack    <= 1'b0;
    end else begin
      cond_code  <= program_status_word[32 +: `SSU_CC_W];
      active_set <= set_of(program_status_word);
      int_ack    <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_priv_block: assert property (@(posedge sys_clk) disable iff (srst)
    priv_fault |-> !$changed(program_status_word))
    else $error("psw changed on privileged fault");
  a_brk_console: assert property (@(posedge sys_clk) disable iff (srst)
    st == ST_IDLE && instr_valid && !fault_valid && op_dec == SSU_OP_BRKP && !dec_fault
    |=> console_mode && $stable(program_status_word))
    else $error("breakpoint did not enter console");
  a_cc_follow: assert property (@(posedge sys_clk) disable iff (srst)
    $changed(program_status_word) |=> cond_code == program_status_word[35:32])
    else $error("condition code not from psw");
  a_no_ack: assert property (@(posedge sys_clk) disable iff (srst)
    !int_ack)
    else $error("simulated interrupt acknowledged");
  a_simulated_interrupt_dev: assert property (@(posedge sys_clk) disable iff (srst)
    st == ST_IDLE && instr_valid && !fault_valid && op_dec == SSU_OP_SIM && !dec_fault
    |=> dev_req && dev_num == $past(operand_addr[9:0]))
    else $error("device number wrong");
  a_af_vec: assert property (@(posedge sys_clk) disable iff (srst)
    st == ST_IDLE && fault_valid |=> mem_req && mem_addr == `SSU_VEC_AF)
    else $error("fault vector not fetched");
  a_svc_vec: assert property (@(posedge sys_clk) disable iff (srst)
    st == ST_IDLE && instr_valid && !fault_valid && op_dec == SSU_OP_CALL
    |=> mem_addr == `SSU_VEC_SVC)
    else $error("call vector not fetched");
  a_set_hold: assert property (@(posedge sys_clk) disable iff (srst)
    $changed(program_status_word) |=> active_set == $past(program_status_word[58:56]))
    else $error("active set lagging");
endmodule

// ### tb/ssu_far_model.sv
// Far side of the unit: low memory with a settable answer delay, one device.
// Assumes one memory and one device request outstanding at a time.
module ssu_far_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Memory
  input  wire logic        mem_req,
  input  wire logic [23:0] mem_addr,
  output logic             mem_ready,
  output logic [31:0]      mem_rdata,
  // Device
  input  wire logic        dev_req,
  input  wire logic [9:0]  dev_num,
  output logic             dev_ready,
  output logic             dev_timeout,
  output logic [31:0]      dev_status,
  // Behaviour
  input  wire logic [1:0]  mem_lat,
  input  wire logic        dev_dead
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [logic [23:0]];
  logic [23:0] m_addr;
  logic [2:0]  m_wait;
  logic        m_busy;
  logic [2:0]  d_wait;
  logic        d_busy;
  logic [9:0]  d_num;

  function automatic logic [31:0] word_at(input logic [23:0] a);
    if (mem.exists(a)) return mem[a];
    return {16'h1000 + a[15:0], 16'h1000 + a[15:0] + 16'h0002};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Memory answer, data line toggles outside the answer cycle
  always @(posedge sys_clk) begin
    mem_ready <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (srst) begin
      m_busy    <= 1'b0;
      mem_rdata <= 32'h5A5A_5A5A;
    end else if (mem_req === 1'b1) begin
      m_busy <= 1'b1;
      m_addr <= mem_addr;
      m_wait <= {1'b0, mem_lat};
    end else if (m_busy && m_wait != 3'h0) begin
      m_wait <= m_wait - 3'h1;
    end else if (m_busy) begin
      m_busy    <= 1'b0;
      mem_ready <= 1'b1;
      mem_rdata <= word_at(m_addr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device status answer, or time-out when the device is dead
  always @(posedge sys_clk) begin
    dev_ready   <= 1'b0;
    dev_timeout <= 1'b0;
    dev_status  <= ~dev_status;
    if (srst) begin
      d_busy     <= 1'b0;
      dev_status <= 32'hA5A5_A5A5;
    end else if (dev_req === 1'b1) begin
      d_busy <= 1'b1;
      d_num  <= dev_num;
      d_wait <= 3'h2;
    end else if (d_busy && d_wait != 3'h0) begin
      d_wait <= d_wait - 3'h1;
    end else if (d_busy) begin
      d_busy      <= 1'b0;
      dev_ready   <= !dev_dead;
      dev_timeout <= dev_dead;
      dev_status  <= {24'h0, 8'h40 ^ d_num[7:0]};
    end
  end
endmodule

// ### tb/status_switch_unit_test.sv
// Self-checking bench for the status switch unit.
// Assumes hw/ on the include path and ssu_pkg compiled first.
`include "ssu_regs.svh"
module status_switch_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ssu_pkg::*;
  typedef struct {logic [7:0] op; logic [3:0] n; logic [31:0] exp;} ssu_row_s;
  logic        sys_clk, srst, instr_valid, fault_valid, mem_req, mem_ready, dev_req;
  logic        dev_ready, dev_timeout, dev_immediate, dev_dead, reg_we, done, priv_fault;
  logic        console_mode, int_ack, pf;
  logic [7:0]  opcode;
  logic [3:0]  r1_field, r2_field, reg_idx, cond_code;
  logic [23:0] operand_addr, instr_addr, next_addr, mem_addr;
  logic [31:0] r1_data, r2_data, r2p1_data, mem_rdata, dev_status, reg_wdata;
  logic [9:0]  dev_num, dn;
  logic [2:0]  reg_set, active_set;
  logic [1:0]  mem_lat;
  logic [63:0] program_status_word, keep;
  logic [15:0] func_sel, fs;
  logic [31:0] wv [16];
  logic [2:0]  ws [16];
  ssu_fault_e  fault_code;
  ssu_row_s    rows [21];
  logic [7:0]  privs [6] = '{8'h18, 8'hC2, 8'h95, 8'hE2, 8'h88, 8'hDF};
  int          bad_count, samples_checked, cycles;

  ssu_main ssu_main_i (.sys_clk(sys_clk), .srst(srst), .instr_valid(instr_valid),
    .opcode(opcode), .r1_field(r1_field), .r2_field(r2_field),
    .operand_addr(operand_addr), .instr_addr(instr_addr), .next_addr(next_addr),
    .r1_data(r1_data), .r2_data(r2_data), .r2p1_data(r2p1_data),
    .fault_valid(fault_valid), .fault_code(fault_code), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .dev_req(dev_req), .dev_num(dev_num), .dev_ready(dev_ready),
    .dev_timeout(dev_timeout), .dev_status(dev_status), .dev_immediate(dev_immediate),
    .reg_we(reg_we), .reg_set(reg_set), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
    .program_status_word(program_status_word), .cond_code(cond_code), .active_set(active_set), .done(done),
    .priv_fault(priv_fault), .console_mode(console_mode), .int_ack(int_ack),
    .func_sel(func_sel));
  ssu_far_model ssu_far_model_i (.sys_clk(sys_clk), .srst(srst), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .dev_req(dev_req), .dev_num(dev_num), .dev_ready(dev_ready),
    .dev_timeout(dev_timeout), .dev_status(dev_status), .mem_lat(mem_lat),
    .dev_dead(dev_dead));

  ////////////////////////////////////////////////////////////////////////////
  // Checking and closing
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      bad_count++;
    end
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Register writes, strobes, hang limit
  always @(posedge sys_clk) begin
    cycles++;
    if (reg_we === 1'b1) begin
      wv[reg_idx] = reg_wdata;
      ws[reg_idx] = reg_set;
    end
    if (dev_req === 1'b1) dn = dev_num;
    fs = fs | func_sel;
    if (!srst) chk(int_ack, 0);
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One instruction or fault, waits for done, then lets cond_code settle
  task automatic put(input bit flt, input logic [7:0] op, input logic [3:0] a, b,
                     input logic [31:0] da, db, dc);
    int n;
    @(posedge sys_clk);
    #10;
    opcode    = op;
    r1_field  = a;
    r2_field  = b;
    r1_data   = da;
    r2_data   = db;
    r2p1_data = dc;
    foreach (wv[k]) wv[k] = 32'hx;
    fs = 16'h0;
    keep = program_status_word;
    if (flt) fault_valid = 1'b1;
    else instr_valid = 1'b1;
    @(posedge sys_clk);
    #10;
    instr_valid = 1'b0;
    fault_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      #10;
      n++;
    end
    if (n == 300) chk(1, 0);
    pf = priv_fault;
    repeat (2) @(posedge sys_clk);
    #10;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {srst, instr_valid, fault_valid, dev_dead, opcode, r1_field, r2_field} = '0;
    {operand_addr, r1_data, r2_data, r2p1_data} = '0;
    srst = 1'b1;
    dev_immediate = 1'b1;
    mem_lat = 2'h1;
    fault_code = SSU_AF_FXDIV0;
    instr_addr = 24'h00_4000;
    next_addr = 24'h00_4004;
    ssu_far_model_i.mem[24'h00_0048] = 32'h0200_0005;
    ssu_far_model_i.mem[24'h00_004C] = 32'h0000_0100;
    for (int k = 0; k < 5; k++) rows[k] = '{8'h00, 4'(k), 32'(k)};
    for (int k = 0; k < 16; k++) rows[5 + k] = '{8'hDF, 4'(k), 32'h1 << k};
    repeat (16) @(posedge sys_clk);
    #10;
    srst = 1'b0;
    chk({program_status_word, console_mode, done, active_set}, 0);
    // Fault codes and system function decode
    foreach (rows[i]) begin
      fault_code = ssu_fault_e'(rows[i].n);
      put(rows[i].op == 8'h00, rows[i].op, rows[i].n, 0, 0, 0, 0);
      if (rows[i].op == 8'h00) begin
        chk(wv[13], rows[i].exp);
        chk(wv[12], {8'h0, next_addr});
        chk(wv[15][23:0], instr_addr);
        chk({ws[12], program_status_word[63:32]}, {3'h2, 32'h0200_0005});
      end else
        chk(fs, rows[i].exp);
    end
    put(0, `SSU_OP_LSW, 0, 2, 0, 32'h0100_000C, 32'h0000_4000);
    chk({program_status_word, cond_code, active_set}, {64'h0100_000C_0000_4000, 4'hC, 3'h1});
    ssu_far_model_i.mem[24'h00_2000] = 32'h0300_0007;
    ssu_far_model_i.mem[24'h00_2004] = 32'h0000_5000;
    operand_addr = 24'h00_2000;
    mem_lat = 2'h3;
    put(0, `SSU_OP_LSW_MEM, 0, 0, 0, 0, 0);
    chk({program_status_word, cond_code, active_set}, {64'h0300_0007_0000_5000, 4'h7, 3'h3});
    put(0, `SSU_OP_XCHG, 4, 6, 0, 32'h0400_0009, 0);
    chk(wv[4], 32'h0300_0007);
    chk({program_status_word, cond_code, active_set}, {64'h0400_0009_0000_5000, 4'h9, 3'h4});
    put(0, `SSU_OP_XCHG, 5, 5, 0, 32'h0600_0001, 0);
    chk({wv[5], program_status_word[63:32]}, {32'h0400_0009, 32'h0400_0009});
    ssu_far_model_i.mem[24'h00_0080] = 32'h0000_3000;
    ssu_far_model_i.mem[24'h00_3000] = 32'h0004_0001;
    ssu_far_model_i.mem[24'h00_0088] = 32'h0500_000A;
    ssu_far_model_i.mem[24'h00_008C] = 32'h0000_7000;
    put(0, `SSU_OP_LSW, 0, 2, 0, 32'h0000_0203, 32'h0000_6000);
    chk({wv[14], wv[13], ws[14]}, {32'h0000_0203, 32'h0000_3000, 3'h5});
    chk(program_status_word[63:32], 32'h0500_000A);
    operand_addr = 24'h00_0ABC;
    put(0, `SSU_OP_SIMULATED_INTERRUPT, 0, 0, 0, 0, 0);
    chk(dn, 10'h2BC);
    chk({wv[3], ws[3]}, {32'h0000_00FC, 3'h0});
    dev_dead = 1'b1;
    dev_immediate = 1'b0;
    put(0, `SSU_OP_SIMULATED_INTERRUPT, 0, 0, 0, 0, 0);
    chk({wv[3], cond_code}, {32'h0000_0004, 4'hA});
    dev_immediate = 1'b1;
    put(0, `SSU_OP_SIMULATED_INTERRUPT, 2, 0, 32'hFFFF_FFF3, 0, 0);
    chk({wv[3], ws[3], cond_code[`SSU_V_FLAG]}, {32'h0000_0004, 3'h3, 1'b1});
    // Protect mode refuses every privileged switch
    put(0, `SSU_OP_LSW, 0, 2, 0, 32'h0000_0100, 32'h0000_0000);
    foreach (privs[i]) begin
      put(0, privs[i], 1, 2, 32'h0000_0001, 32'h0000_0000, 32'h0);
      chk({pf, program_status_word, console_mode, fs}, {1'b1, 64'h0000_0100_0000_0000, 17'h0});
    end
    ssu_far_model_i.mem[24'h00_0098] = 32'h0100_0002;
    operand_addr = 24'h12_3456;
    put(0, `SSU_OP_SVC, 5, 0, 0, 0, 0);
    chk({pf, wv[13], ws[13]}, {1'b0, 32'h0012_3456, 3'h1});
    chk({wv[14], wv[15]}, 64'h0000_0100_0000_4004);
    chk({program_status_word[63:32], program_status_word[23:0], cond_code}, {32'h0100_0002, 24'h00_10A6, 4'h2});
    put(0, `SSU_OP_BRK, 0, 0, 0, 0, 0);
    chk({pf, console_mode, program_status_word}, {1'b0, 1'b1, keep});
    tally_and_finish();
  end
endmodule
